// file: core/sls_consts.svh
// Timing counts and field values for the status lamp and button sequencer.
// Assumes a 100 MHz system clock; all lamp timing is counted in millisecond ticks.
`ifndef SLS_CONSTS_SVH
`define SLS_CONSTS_SVH

// ---------------------------------------------------------------
// Clock and tick
// ---------------------------------------------------------------
`define SLS_CLK_HZ 100000000
`define SLS_TICK_HZ 1000
`define SLS_CLK_PER_MS (`SLS_CLK_HZ / `SLS_TICK_HZ)

// ---------------------------------------------------------------
// Start-up and run timing, in ms
// ---------------------------------------------------------------
`define SLS_LAMP_TEST_MS 16'h03E8
`define SLS_HW_OK_MS 16'h07D0
`define SLS_CONN_ON_MS 16'h0064
`define SLS_CONN_OFF_MS 16'h03E8
`define SLS_RUN_ON_MS 16'h01F4
`define SLS_RUN_OFF_MS 16'h01F4
`define SLS_TERM_ON_MS 16'h0064
`define SLS_TERM_OFF_MS 16'h0064
`define SLS_TRX_PULSE_MS 16'h000A

// ---------------------------------------------------------------
// Run error green patterns, in ms
// ---------------------------------------------------------------
`define SLS_ERR1_ON_MS 16'h000A
`define SLS_ERR1_OFF_MS 16'h03E8
`define SLS_ERR2_ON_MS 16'h0064
`define SLS_ERR2_OFF_MS 16'h0064
`define SLS_ERR3_ON_MS 16'h01F4
`define SLS_ERR3_OFF_MS 16'h01F4

// ---------------------------------------------------------------
// Button hold timing, in ms
// ---------------------------------------------------------------
`define SLS_BTN_ON_FROM_MS 16'h03E8
`define SLS_BTN_DARK_FROM_MS 16'h07D0
`define SLS_BTN_FLASH_FROM_MS 16'h0BB8
`define SLS_BTN_FACTORY_MS 16'h2710
`define SLS_BTN_FLASH_HALF_MS 16'h0064

// ---------------------------------------------------------------
// Firmware update flash: 20 Hz, 25 ms on and 25 ms off
// ---------------------------------------------------------------
`define SLS_FW_FLASH_HZ 20
`define SLS_FW_HALF_MS (16'(`SLS_TICK_HZ / (2 * `SLS_FW_FLASH_HZ)))

// ---------------------------------------------------------------
// Run error class codes
// ---------------------------------------------------------------
`define SLS_ERR_NONE 2'h0
`define SLS_ERR_CLASS1 2'h1
`define SLS_ERR_CLASS2 2'h2
`define SLS_ERR_CLASS3 2'h3

`endif

// file: core/sls_pkg.sv
// Types shared by the status lamp and button sequencer.
// Assumes sls_consts.svh supplies all numeric values.
package sls_pkg;

  // ---------------------------------------------------------------
  // Main sequence states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_LAMP_TEST,
    ST_HW_CHECK,
    ST_HW_OK,
    ST_CONNECT,
    ST_RUN,
    ST_TERMINAL,
    ST_FAULT,
    ST_FW_UPDATE,
    ST_OFF
  } sls_state_t;

  // ---------------------------------------------------------------
  // Button hold states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BTN_IDLE,
    BTN_HOLD,
    BTN_DONE
  } sls_btn_t;

endpackage : sls_pkg

// file: core/sls_tick_gen.sv
// Millisecond tick divider for the status lamp sequencer.
// Assumes one free-running system clock; tick is one cycle wide.
`timescale 1ns/1ps

module sls_tick_gen #(
  parameter int unsigned DIV = 100000
) (
  input wire logic clk_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  output logic tick_o // One-cycle pulse every DIV cycles
);

  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  logic [31:0] cnt_ff;

  // Count DIV cycles, pulse on the last one
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_ff == 32'(DIV - 1)) begin
      cnt_ff <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      tick_o <= 1'b0;
    end
  end

endmodule : sls_tick_gen

// file: core/sls_sequencer.sv
// Status lamp and pushbutton sequencer: start-up, run, error, update and hold.
// Assumes status inputs and the button are clean and synchronous to clk_i.
//
// Functional notes
// - All lamps on together for one second at start-up.
// - Hardware check passed: green steady on for two seconds.
// - Connecting: green 100 ms on, one second off, repeating.
// - Normal run: green 500 ms on, 500 ms off.
// - Terminal mode: network disabled, transceiver traffic goes to terminal only.
// - Terminal mode: green 100 ms on, 100 ms off.
// - Each transceiver exchange pulses the orange lamp for 10 ms.
// - Critical hardware fault: error state, red lamp steady on.
// - Run error: keep operating, red lamp steady on.
// - Green encodes error class: 10/1000, 100/100, 500/500 ms.
// - Class one: network start, interface, service, cloud failures.
// - Class two: transceiver silent; class three: memory card fault.
// - Hold: all on 1-2 s, dark 2-3 s, flash 100/100 ms to 10 s.
// - Held ten seconds: lamps off, factory restore, self reset.
// - Released within one second: hold abandoned, back to run.
// - Released between one and ten seconds: switch off.
// - Firmware check and write: all lamps flash together at 20 Hz.
// - Check fails: start previous firmware; write succeeds: start new one.
`timescale 1ns/1ps
`include "sls_consts.svh"

module sls_sequencer import sls_pkg::*; #(
  parameter int unsigned CLK_PER_MS = `SLS_CLK_PER_MS
) (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic arst_n_i, // Async reset, active low
  input wire logic hw_check_done_i, // Hardware check finished
  input wire logic hw_fault_i, // Critical fault found, valid with done
  input wire logic net_connected_i, // Network (and cloud) connected
  input wire logic terminal_i, // Attached to host terminal tool
  input wire logic trx_activity_i, // Transceiver exchange pulse
  input wire logic err_net_start_i, // Network start failure
  input wire logic err_net_if_i, // Network interface fatal failure
  input wire logic err_service_i, // Network service failure
  input wire logic err_cloud_conn_i, // Cloud connection failure
  input wire logic err_cloud_reg_i, // Cloud registration failure
  input wire logic err_upload_i, // Cloud upload failure
  input wire logic err_download_i, // Cloud download failure
  input wire logic err_trx_silent_i, // Transceiver not responding
  input wire logic err_card_i, // Memory card fault
  input wire logic fw_update_i, // Firmware update in progress
  input wire logic fw_check_fail_i, // Image check failed pulse
  input wire logic fw_write_ok_i, // Image write succeeded pulse
  input wire logic button_i, // Pushbutton, high while pressed
  output logic led_green_o, // Green lamp
  output logic led_orange_o, // Orange lamp
  output logic led_red_o, // Red lamp
  output logic hw_check_start_o, // Start hardware check pulse
  output logic net_enable_o, // Network communication allowed
  output logic term_forward_o, // Transceiver traffic to terminal only
  output logic [1:0] err_class_o, // Active run error class
  output logic power_off_o, // Switch off, held
  output logic factory_restore_o, // Factory restore pulse
  output logic self_reset_o, // Self reset pulse
  output logic boot_prev_fw_o, // Start previous firmware pulse
  output logic boot_new_fw_o // Start new firmware pulse
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Counter compare against a length in ms, on the last tick of it
  function automatic logic at_end(input logic [15:0] cnt, input logic [15:0] len);
    at_end = (cnt == len - 16'h1);
  endfunction : at_end

  // Saturating ms increment
  function automatic logic [15:0] inc_sat(input logic [15:0] cnt);
    inc_sat = (cnt == 16'hFFFF) ? cnt : cnt + 16'h1;
  endfunction : inc_sat

  // ---------------------------------------------------------------
  // Millisecond tick
  // ---------------------------------------------------------------
  logic tick;

  sls_tick_gen #(
    .DIV(CLK_PER_MS)
  ) u_tick (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tick_o(tick)
  );

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  sls_state_t state_ff;
  sls_state_t nxt_state;
  sls_btn_t btn_ff;
  logic [15:0] state_ms_ff;
  logic [15:0] pat_ff;
  logic [2:0] pat_id_ff;
  logic [2:0] pat_id;
  logic [15:0] pat_on;
  logic [15:0] pat_per;
  logic [15:0] btn_ms_ff;
  logic [6:0] btn_sub_ff;
  logic btn_phase_ff;
  logic [15:0] trx_ms_ff;
  logic [1:0] err_class;
  logic run_state;
  logic btn_factory;
  logic btn_release_off;
  logic pat_lit;

  // ---------------------------------------------------------------
  // Error classification
  // ---------------------------------------------------------------
  // Class one wins: it blocks the cloud, the most visible loss
  always_comb begin
    if (err_net_start_i || err_net_if_i || err_service_i || err_cloud_conn_i ||
        err_cloud_reg_i || err_upload_i || err_download_i) begin
      err_class = `SLS_ERR_CLASS1;
    end else if (err_trx_silent_i) begin
      err_class = `SLS_ERR_CLASS2;
    end else if (err_card_i) begin
      err_class = `SLS_ERR_CLASS3;
    end else begin
      err_class = `SLS_ERR_NONE;
    end
  end

  assign run_state = (state_ff == ST_CONNECT) || (state_ff == ST_RUN) ||
                     (state_ff == ST_TERMINAL);

  // ---------------------------------------------------------------
  // Button hold decisions
  // ---------------------------------------------------------------
  assign btn_factory = (btn_ff == BTN_HOLD) && button_i && tick &&
                       at_end(btn_ms_ff, `SLS_BTN_FACTORY_MS);
  assign btn_release_off = (btn_ff == BTN_HOLD) && !button_i &&
                           (btn_ms_ff >= `SLS_BTN_ON_FROM_MS);

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  // Update has priority over every state but off and fault
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_LAMP_TEST: begin
        if (tick && at_end(state_ms_ff, `SLS_LAMP_TEST_MS)) begin
          nxt_state = ST_HW_CHECK;
        end
      end
      ST_HW_CHECK: begin
        if (hw_check_done_i) begin
          nxt_state = hw_fault_i ? ST_FAULT : ST_HW_OK;
        end
      end
      ST_HW_OK: begin
        if (tick && at_end(state_ms_ff, `SLS_HW_OK_MS)) begin
          nxt_state = ST_CONNECT;
        end
      end
      ST_CONNECT: begin
        if (terminal_i) begin
          nxt_state = ST_TERMINAL;
        end else if (net_connected_i) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (terminal_i) begin
          nxt_state = ST_TERMINAL;
        end else if (!net_connected_i) begin
          nxt_state = ST_CONNECT;
        end
      end
      ST_TERMINAL: begin
        if (!terminal_i) begin
          nxt_state = net_connected_i ? ST_RUN : ST_CONNECT;
        end
      end
      ST_FAULT: begin
        nxt_state = ST_FAULT;
      end
      ST_FW_UPDATE: begin
        if (fw_check_fail_i || fw_write_ok_i) begin
          nxt_state = ST_LAMP_TEST;
        end
      end
      ST_OFF: begin
        nxt_state = ST_OFF;
      end
    endcase
    if (fw_update_i && (state_ff != ST_FAULT) && (state_ff != ST_OFF) &&
        (state_ff != ST_FW_UPDATE)) begin
      nxt_state = ST_FW_UPDATE;
    end
    if (run_state && btn_factory) begin
      nxt_state = ST_LAMP_TEST;
    end else if (run_state && btn_release_off) begin
      nxt_state = ST_OFF;
    end
  end

  // State register and its ms counter, cleared on every change
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= ST_LAMP_TEST;
      state_ms_ff <= 16'h0;
    end else if (nxt_state != state_ff) begin
      state_ff <= nxt_state;
      state_ms_ff <= 16'h0;
    end else if (tick) begin
      state_ms_ff <= inc_sat(state_ms_ff);
    end
  end

  // ---------------------------------------------------------------
  // Button hold timer
  // ---------------------------------------------------------------
  // Only run states accept a hold; a press held elsewhere is ignored
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      btn_ff <= BTN_IDLE;
      btn_ms_ff <= 16'h0;
      btn_sub_ff <= 7'h0;
      btn_phase_ff <= 1'b0;
    end else begin
      unique case (btn_ff)
        BTN_IDLE: begin
          btn_ms_ff <= 16'h0;
          btn_sub_ff <= 7'h0;
          btn_phase_ff <= 1'b0;
          if (button_i && run_state) begin
            btn_ff <= BTN_HOLD;
          end
        end
        BTN_HOLD: begin
          if (!button_i || !run_state) begin
            btn_ff <= BTN_IDLE;
          end else if (btn_factory) begin
            btn_ff <= BTN_DONE;
          end else if (tick) begin
            btn_ms_ff <= inc_sat(btn_ms_ff);
            if (at_end({9'h0, btn_sub_ff}, `SLS_BTN_FLASH_HALF_MS)) begin
              btn_sub_ff <= 7'h0;
              btn_phase_ff <= ~btn_phase_ff;
            end else begin
              btn_sub_ff <= btn_sub_ff + 7'h1;
            end
          end
        end
        BTN_DONE: begin
          // Wait for release so the restart does not begin a new hold
          if (!button_i) begin
            btn_ff <= BTN_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Green pattern selection
  // ---------------------------------------------------------------
  always_comb begin
    pat_id = 3'h0;
    pat_on = 16'h0;
    pat_per = 16'h1;
    if (run_state && err_class == `SLS_ERR_CLASS1) begin
      pat_id = 3'h4;
      pat_on = `SLS_ERR1_ON_MS;
      pat_per = `SLS_ERR1_ON_MS + `SLS_ERR1_OFF_MS;
    end else if (run_state && err_class == `SLS_ERR_CLASS2) begin
      pat_id = 3'h5;
      pat_on = `SLS_ERR2_ON_MS;
      pat_per = `SLS_ERR2_ON_MS + `SLS_ERR2_OFF_MS;
    end else if (run_state && err_class == `SLS_ERR_CLASS3) begin
      pat_id = 3'h6;
      pat_on = `SLS_ERR3_ON_MS;
      pat_per = `SLS_ERR3_ON_MS + `SLS_ERR3_OFF_MS;
    end else if (state_ff == ST_CONNECT) begin
      pat_id = 3'h1;
      pat_on = `SLS_CONN_ON_MS;
      pat_per = `SLS_CONN_ON_MS + `SLS_CONN_OFF_MS;
    end else if (state_ff == ST_RUN) begin
      pat_id = 3'h2;
      pat_on = `SLS_RUN_ON_MS;
      pat_per = `SLS_RUN_ON_MS + `SLS_RUN_OFF_MS;
    end else if (state_ff == ST_TERMINAL) begin
      pat_id = 3'h3;
      pat_on = `SLS_TERM_ON_MS;
      pat_per = `SLS_TERM_ON_MS + `SLS_TERM_OFF_MS;
    end else if (state_ff == ST_FW_UPDATE) begin
      pat_id = 3'h7;
      pat_on = `SLS_FW_HALF_MS;
      pat_per = `SLS_FW_HALF_MS + `SLS_FW_HALF_MS;
    end
  end

  // Pattern phase restarts whenever the pattern itself changes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pat_ff <= 16'h0;
      pat_id_ff <= 3'h0;
    end else if (pat_id != pat_id_ff || nxt_state != state_ff) begin
      pat_ff <= 16'h0;
      pat_id_ff <= pat_id;
    end else if (tick) begin
      pat_ff <= at_end(pat_ff, pat_per) ? 16'h0 : pat_ff + 16'h1;
    end
  end

  assign pat_lit = (pat_ff < pat_on);

  // ---------------------------------------------------------------
  // Orange activity pulse
  // ---------------------------------------------------------------
  // Retriggers on each exchange; length is 9 to 10 ms against the tick
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trx_ms_ff <= 16'h0;
    end else if (trx_activity_i) begin
      trx_ms_ff <= `SLS_TRX_PULSE_MS;
    end else if (tick && trx_ms_ff != 16'h0) begin
      trx_ms_ff <= trx_ms_ff - 16'h1;
    end
  end

  // ---------------------------------------------------------------
  // Lamp outputs
  // ---------------------------------------------------------------
  // Hold display overrides run display once the hold passes one second
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      led_green_o <= 1'b0;
      led_orange_o <= 1'b0;
      led_red_o <= 1'b0;
    end else if (btn_ff == BTN_DONE || state_ff == ST_OFF) begin
      led_green_o <= 1'b0;
      led_orange_o <= 1'b0;
      led_red_o <= 1'b0;
    end else if (btn_ff == BTN_HOLD && btn_ms_ff >= `SLS_BTN_ON_FROM_MS) begin
      if (btn_ms_ff < `SLS_BTN_DARK_FROM_MS) begin
        led_green_o <= 1'b1;
        led_orange_o <= 1'b1;
        led_red_o <= 1'b1;
      end else if (btn_ms_ff < `SLS_BTN_FLASH_FROM_MS) begin
        led_green_o <= 1'b0;
        led_orange_o <= 1'b0;
        led_red_o <= 1'b0;
      end else begin
        led_green_o <= ~btn_phase_ff;
        led_orange_o <= ~btn_phase_ff;
        led_red_o <= ~btn_phase_ff;
      end
    end else begin
      unique case (state_ff)
        ST_LAMP_TEST: begin
          led_green_o <= 1'b1;
          led_orange_o <= 1'b1;
          led_red_o <= 1'b1;
        end
        ST_HW_OK: begin
          led_green_o <= 1'b1;
          led_orange_o <= trx_ms_ff != 16'h0;
          led_red_o <= 1'b0;
        end
        ST_FAULT: begin
          led_green_o <= 1'b0;
          led_orange_o <= trx_ms_ff != 16'h0;
          led_red_o <= 1'b1;
        end
        ST_FW_UPDATE: begin
          led_green_o <= pat_lit;
          led_orange_o <= pat_lit;
          led_red_o <= pat_lit;
        end
        ST_CONNECT, ST_RUN, ST_TERMINAL: begin
          led_green_o <= pat_lit;
          led_orange_o <= trx_ms_ff != 16'h0;
          led_red_o <= err_class != `SLS_ERR_NONE;
        end
        default: begin
          led_green_o <= 1'b0;
          led_orange_o <= trx_ms_ff != 16'h0;
          led_red_o <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------
  // Pulses and levels registered so they are glitch free at the pins
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hw_check_start_o <= 1'b0;
      net_enable_o <= 1'b0;
      term_forward_o <= 1'b0;
      err_class_o <= `SLS_ERR_NONE;
      power_off_o <= 1'b0;
      factory_restore_o <= 1'b0;
      self_reset_o <= 1'b0;
      boot_prev_fw_o <= 1'b0;
      boot_new_fw_o <= 1'b0;
    end else begin
      hw_check_start_o <= (state_ff == ST_LAMP_TEST) && (nxt_state == ST_HW_CHECK);
      net_enable_o <= (nxt_state == ST_CONNECT) || (nxt_state == ST_RUN);
      term_forward_o <= (nxt_state == ST_TERMINAL);
      err_class_o <= run_state ? err_class : `SLS_ERR_NONE;
      power_off_o <= power_off_o || (run_state && btn_release_off);
      factory_restore_o <= run_state && btn_factory;
      self_reset_o <= run_state && btn_factory;
      boot_prev_fw_o <= (state_ff == ST_FW_UPDATE) && fw_check_fail_i;
      boot_new_fw_o <= (state_ff == ST_FW_UPDATE) && !fw_check_fail_i &&
                       fw_write_ok_i;
    end
  end

endmodule : sls_sequencer

// file: test/sls_panel.sv
// Pushbutton stand-in for the lamp sequencer bench.
// Assumes the bench calls press just after a falling clock edge.
`timescale 1ns/1ps
module sls_panel #(
  parameter int unsigned CPM = 2
) (
  input wire logic clk_i, // System clock
  output logic button_o // High while pressed
);
  // A person holds the button for whole milliseconds, then lets go
  task automatic press(input int ms);
    button_o = 1'b1;
    repeat (ms * CPM) @(negedge clk_i);
    button_o = 1'b0;
  endtask : press
  initial button_o = 1'b0;
endmodule : sls_panel

// file: test/sls_checker.sv
// Port checks for the lamp and button sequencer, bound to each instance.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module sls_checker (
  input wire logic clk_i, // Clock
  input wire logic arst_n_i, // Reset
  input wire logic button_i, // Button
  input wire logic trx_activity_i, // Exchange
  input wire logic fw_update_i, // Update
  input wire logic err_trx_silent_i, // Class two
  input wire logic hw_check_start_o, // Check start
  input wire logic led_green_o, // Green
  input wire logic led_orange_o, // Orange
  input wire logic led_red_o, // Red
  input wire logic net_enable_o, // Net on
  input wire logic term_forward_o, // Terminal
  input wire logic [1:0] err_class_o, // Class
  input wire logic power_off_o, // Off
  input wire logic factory_restore_o, // Factory
  input wire logic self_reset_o, // Restart
  input wire logic boot_prev_fw_o, // Old image
  input wire logic boot_new_fw_o // New image
);
  logic first_ff;
  // High only until the first edge after reset lets go
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      first_ff <= 1'b1;
    end else begin
      first_ff <= 1'b0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_all_on; led_green_o && led_orange_o && led_red_o; endsequence
  sequence s_off_held; power_off_o [*3]; endsequence
  property p_lamp_test; first_ff |=> s_all_on; endproperty
  a_lamp_test: assert property (p_lamp_test) else $error("start lamps");
  // Check start is one cycle wide, and the lamp test is over by the next cycle
  property p_chk_start; hw_check_start_o |=> !hw_check_start_o && !led_green_o && !led_red_o;
  endproperty
  a_chk_start: assert property (p_chk_start) else $error("check start");
  // Three cycles of error give the lamp register time to follow
  property p_red_err; (err_class_o != 2'h0 && !button_i) [*3] |-> led_red_o; endproperty
  a_red_err: assert property (p_red_err) else $error("red lamp");
  property p_term_net; term_forward_o |-> !net_enable_o; endproperty
  a_term_net: assert property (p_term_net) else $error("net in terminal");
  // Hold and update override the lamps, so they are left out
  property p_orange; trx_activity_i && (net_enable_o || term_forward_o) && !button_i
    && !fw_update_i |-> ##[1:3] led_orange_o; endproperty
  a_orange: assert property (p_orange) else $error("orange lamp");
  property p_cls_two; (err_class_o == 2'h2)
    |-> $past(err_trx_silent_i) || $past(err_trx_silent_i, 2); endproperty
  a_cls_two: assert property (p_cls_two) else $error("class two");
  property p_factory; (factory_restore_o || self_reset_o)
    |-> factory_restore_o && self_reset_o ##1 !factory_restore_o; endproperty
  a_factory: assert property (p_factory) else $error("factory pulse");
  property p_off_sticky; power_off_o |=> power_off_o; endproperty
  a_off_sticky: assert property (p_off_sticky) else $error("off lost");
  property p_off_dark; s_off_held |-> !led_green_o && !led_orange_o && !led_red_o; endproperty
  a_off_dark: assert property (p_off_dark) else $error("lamps when off");
  property p_boot; (boot_prev_fw_o || boot_new_fw_o)
    |-> !(boot_prev_fw_o && boot_new_fw_o) ##[0:2] s_all_on; endproperty
  a_boot: assert property (p_boot) else $error("boot pulse");
endmodule : sls_checker
bind sls_sequencer sls_checker sls_checker_i (.*);

// file: test/tb.sv
// Self-checking bench for the status lamp and button sequencer.
// Assumes a 2-cycle ms tick so the ten-second hold fits the run.
`timescale 1ns/1ps
module tb;
  localparam int unsigned CPM = 2;
  logic clk, arst_n, done, fault, conn, term, trx, fwu, fwf, fwok, btn;
  logic fac_seen = 1'b0;
  logic g, o, r, ne, tf, po, fr, bp, bn;
  logic [8:0] errs;
  logic [1:0] cls;
  logic [1:0] ec;
  logic [2:0] lamps;
  int errors, total_checks, cyc, on;
  assign lamps = {g, o, r};
  sls_sequencer #(.CLK_PER_MS(CPM)) sls_sequencer_i (.clk_i(clk), .arst_n_i(arst_n),
    .hw_check_done_i(done), .hw_fault_i(fault), .net_connected_i(conn), .terminal_i(term),
    .trx_activity_i(trx), .err_net_start_i(errs[0]), .err_net_if_i(errs[1]),
    .err_service_i(errs[2]), .err_cloud_conn_i(errs[3]), .err_cloud_reg_i(errs[4]),
    .err_upload_i(errs[5]), .err_download_i(errs[6]), .err_trx_silent_i(errs[7]),
    .err_card_i(errs[8]), .fw_update_i(fwu), .fw_check_fail_i(fwf), .fw_write_ok_i(fwok),
    .button_i(btn), .led_green_o(g), .led_orange_o(o), .led_red_o(r), .hw_check_start_o(),
    .net_enable_o(ne), .term_forward_o(tf), .err_class_o(cls), .power_off_o(po),
    .factory_restore_o(fr), .self_reset_o(), .boot_prev_fw_o(bp), .boot_new_fw_o(bn));
  sls_panel #(.CPM(CPM)) sls_panel_i (.clk_i(clk), .button_o(btn));
  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %b, expected %b", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_ms(input int ms);
    repeat (ms * CPM) @(negedge clk);
  endtask : wait_ms
  // From lamp test start: pass the check, sit out the green two seconds
  task automatic bring_up();
    wait_ms(1005);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    wait_ms(2010);
  endtask : bring_up
  // Ends an update with one result pulse; the boot pulse stands this cycle
  task automatic fw_end(ref logic s);
    s = 1'b1;
    fwu = 1'b0;
    @(negedge clk);
    s = 1'b0;
  endtask : fw_end
  task automatic wrap_up();
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, well above the planned run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      errors++;
      wrap_up();
    end
  end
  always @(posedge clk) if (fr) fac_seen <= 1'b1;
  initial begin
    {arst_n, done, fault, conn, term, trx, fwu, fwf, fwok} = '0;
    errs = '0;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    wait_ms(500);
    chk(lamps, 3'b111);
    wait_ms(505);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    wait_ms(1000);
    chk(lamps, 3'b100);
    wait_ms(1050);
    chk(lamps, 3'b100);
    wait_ms(500);
    chk({g, ne, tf}, 3'b010);
    conn = 1'b1;
    wait_ms(250);
    chk(lamps, 3'b100);
    wait_ms(500);
    chk(lamps, 3'b000);
    trx = 1'b1;
    @(negedge clk);
    trx = 1'b0;
    wait_ms(5);
    chk(lamps, 3'b010);
    wait_ms(10);
    chk(lamps, 3'b000);
    term = 1'b1;
    wait_ms(50);
    chk({g, ne, tf}, 3'b101);
    wait_ms(100);
    chk(lamps, 3'b000);
    term = 1'b0;
    // Every error source once, with its class and green duty
    for (int i = 0; i < 9; i++) begin
      errs = 9'h001 << i;
      ec = (i < 7) ? 2'h1 : (i == 7) ? 2'h2 : 2'h3;
      on = (ec == 2'h1) ? 10 : (ec == 2'h2) ? 100 : 500;
      wait_ms(5);
      chk({1'b0, cls}, {1'b0, ec});
      chk(lamps, 3'b101);
      wait_ms(on);
      chk(lamps, 3'b001);
      errs = '0;
      wait_ms(5);
    end
    fwu = 1'b1;
    wait_ms(10);
    chk(lamps, 3'b111);
    wait_ms(25);
    chk(lamps, 3'b000);
    fw_end(fwf);
    chk({1'b0, bp, bn}, 3'b010);
    wait_ms(500);
    chk(lamps, 3'b111);
    fwu = 1'b1;
    wait_ms(60);
    fw_end(fwok);
    chk({1'b0, bp, bn}, 3'b001);
    bring_up();
    sls_panel_i.press(500);
    wait_ms(2);
    chk({1'b0, ne, po}, 3'b010);
    fork
      sls_panel_i.press(10100);
      begin
        wait_ms(1500);
        chk(lamps, 3'b111);
        wait_ms(1000);
        chk(lamps, 3'b000);
        wait_ms(550);
        chk(lamps, 3'b111);
        wait_ms(100);
        chk(lamps, 3'b000);
        wait_ms(6900);
        chk(lamps, 3'b000);
      end
    join
    chk({2'b00, fac_seen}, 3'b001);
    wait_ms(500);
    chk(lamps, 3'b111);
    bring_up();
    sls_panel_i.press(5000);
    wait_ms(2);
    chk({po, g, r}, 3'b100);
    arst_n = 1'b0;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    wait_ms(1005);
    {fault, done} = 2'b11;
    @(negedge clk);
    done = 1'b0;
    wait_ms(3000);
    chk({1'b0, g, r}, 3'b001);
    wrap_up();
  end
endmodule : tb
